// >>> common/aq_pkg.sv
package aq_pkg;
  // Bus geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;
  localparam int REG_W = 16;
  localparam int IDX_SHIFT = 2;
  // Register word indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTL_A = 8'h0b;
  localparam logic [7:0] IDX_CTL_B = 8'h0c;
  localparam logic [7:0] IDX_ONE_SHOT = 8'h0d;
  localparam logic [7:0] IDX_CONT_FORCE = 8'h0e;
  localparam logic [7:0] IDX_INT_STATUS = 8'h10;
  localparam logic [7:0] IDX_INT_MASK = 8'h11;
  localparam logic [7:0] IDX_STATE = 8'h12;
  // Reset value and writable bits of each register
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] CTL_MASK = 16'h0fff;
  localparam logic [REG_W-1:0] OSF_MASK = 16'h001b;
  localparam logic [REG_W-1:0] CSF_MASK = 16'h000f;
  // Action fields of an output control word, two bits each
  localparam int F_ZERO = 0;
  localparam int F_PRD = 2;
  localparam int F_A_UP = 4;
  localparam int F_A_DOWN = 6;
  localparam int F_B_UP = 8;
  localparam int F_B_DOWN = 10;
  // One-shot force fields
  localparam int F_OSF_ACT_A = 0;
  localparam int F_OSF_GO_A = 2;
  localparam int F_OSF_ACT_B = 3;
  localparam int F_OSF_GO_B = 5;
  // Continuous force fields and codes
  localparam int F_CSF_A = 0;
  localparam int F_CSF_B = 2;
  localparam logic [1:0] CSF_LOW = 2'h1;
  localparam logic [1:0] CSF_HIGH = 2'h2;
  // Event bits in the status, mask and event outputs
  localparam int EV_N = 4;
  localparam int EV_ZERO = 0;
  localparam int EV_PRD = 1;
  localparam int EV_CMP_A = 2;
  localparam int EV_CMP_B = 3;
  // State register bits
  localparam int ST_PWM_A = 0;
  localparam int ST_PWM_B = 1;
  localparam int ST_DIR = 2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Output actions and counter modes
  typedef enum logic [1:0] {ACT_NONE, ACT_CLEAR, ACT_SET, ACT_TOGGLE} action_t;
  typedef enum logic [1:0] {MODE_UP, MODE_DOWN, MODE_UPDOWN, MODE_FROZEN} count_mode_t;
  // Byte address of a register index
  function automatic logic [AXI_AW-1:0] byte_addr(input logic [7:0] idx);
    return AXI_AW'({idx, 2'h0});
  endfunction
  // Action held in a two-bit field of a control word
  function automatic action_t field_action(input logic [REG_W-1:0] word, input int pos);
    return action_t'(word[pos +: 2]);
  endfunction
endpackage

// >>> common/action_if.sv
interface action_if;
  logic zero_match;          // Counter equals zero
  logic period_match;        // Counter equals period
  logic cmp_a_match;         // Counter equals compare A
  logic cmp_b_match;         // Counter equals compare B
  logic dir_up;              // Counter is incrementing
  aq_pkg::count_mode_t mode; // Counter mode
  logic [aq_pkg::REG_W-1:0] ctl; // Action control word
  aq_pkg::action_t action;   // Resolved action
  // Owner of the events and the control word
  modport source(output zero_match, period_match, cmp_a_match, cmp_b_match, dir_up, mode, ctl,
    input action);
  // Priority resolver
  modport resolver(input zero_match, period_match, cmp_a_match, cmp_b_match, dir_up, mode, ctl,
    output action);
endinterface

// >>> hw/action_resolver.sv
module action_resolver import aq_pkg::*; (
  // Events and control word in, action out
  action_if.resolver bus
);
  logic up_phase;    // Direction used to qualify compare matches
  logic a_up;        // Compare A while counting up
  logic a_down;      // Compare A while counting down
  logic b_up;        // Compare B while counting up
  logic b_down;      // Compare B while counting down
  logic [4:0] ev;    // Candidate events, index 0 is the strongest
  int pos [5];       // Control field of each candidate

  // Direction qualification of compare matches
  always_comb begin
    case (bus.mode)
      MODE_UP: up_phase = 1'b1;
      MODE_DOWN: up_phase = 1'b0;
      default: up_phase = bus.dir_up;
    endcase
    a_up = bus.cmp_a_match && up_phase;
    a_down = bus.cmp_a_match && !up_phase;
    b_up = bus.cmp_b_match && up_phase;
    b_down = bus.cmp_b_match && !up_phase;
  end

  // Candidate list in priority order for the present mode
  always_comb begin
    ev = '0;
    pos = '{default: 0};
    case (bus.mode)
      MODE_UP: begin
        ev = {1'b0, bus.zero_match, a_up, b_up, bus.period_match};
        pos = '{F_PRD, F_B_UP, F_A_UP, F_ZERO, F_ZERO};
      end
      MODE_DOWN: begin
        ev = {1'b0, bus.period_match, a_down, b_down, bus.zero_match};
        pos = '{F_ZERO, F_B_DOWN, F_A_DOWN, F_PRD, F_PRD};
      end
      MODE_UPDOWN: begin
        if (up_phase) begin
          ev = {a_down, b_down, bus.zero_match, a_up, b_up};
          pos = '{F_B_UP, F_A_UP, F_ZERO, F_B_DOWN, F_A_DOWN};
        end else begin
          ev = {a_up, b_up, bus.period_match, a_down, b_down};
          pos = '{F_B_DOWN, F_A_DOWN, F_PRD, F_B_UP, F_A_UP};
        end
      end
      default: begin
        ev = '0;
      end
    endcase
  end

  // Strongest event with a configured action decides; weaker ones are overridden
  always_comb begin
    bus.action = ACT_NONE;
    for (int i = 4; i >= 0; i--) begin
      if (ev[i] && field_action(bus.ctl, pos[i]) != ACT_NONE) begin
        bus.action = field_action(bus.ctl, pos[i]);
      end
    end
  end
endmodule

// >>> hw/pwm_action_qualifier.sv
// Our own choice: the AXI4-Lite interface to the registers.
module pwm_action_qualifier import aq_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [AXI_SW-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Time-base and compare events
  input wire logic zero_match_i,
  input wire logic period_match_i,
  input wire logic compare_a_match_i,
  input wire logic compare_b_match_i,
  input wire logic count_dir_up_i,
  input wire logic [1:0] count_mode_i,
  // PWM outputs, event forwarding and interrupt
  output logic pwm_out_a_o,
  output logic pwm_out_b_o,
  output logic [EV_N-1:0] event_o,
  output logic irq_o
);
  // Software visible registers
  logic [REG_W-1:0] ctl_a;        // Output A action control
  logic [REG_W-1:0] ctl_b;        // Output B action control
  logic [REG_W-1:0] osf;          // One-shot force actions
  logic [REG_W-1:0] csf_shadow;   // Continuous force, written by software
  logic [REG_W-1:0] csf_active;   // Continuous force, in use
  logic [EV_N-1:0] int_status;    // Sticky event flags
  logic [EV_N-1:0] int_mask;      // Interrupt enables
  // One-shot force strobes
  logic osf_go_a;
  logic osf_go_b;
  // Captured write request
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [AXI_SW-1:0] wr_strb;
  logic wr_fire;                  // Both halves held, response not yet given
  logic [EV_N-1:0] events;        // Incoming events by bit
  logic [EV_N-1:0] int_clear;     // Write-one-to-clear bits
  logic [AXI_DW-1:0] rd_word;     // Read mux result

  // Byte-lane merge of a 16-bit register
  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
      input logic [AXI_DW-1:0] data, input logic [AXI_SW-1:0] strb,
      input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res & mask;
  endfunction

  // Address decode shared by reads and writes
  function automatic logic mapped(input logic [AXI_AW-1:0] addr);
    return addr == byte_addr(IDX_CTL_A) || addr == byte_addr(IDX_CTL_B)
      || addr == byte_addr(IDX_ONE_SHOT) || addr == byte_addr(IDX_CONT_FORCE)
      || addr == byte_addr(IDX_INT_STATUS) || addr == byte_addr(IDX_INT_MASK)
      || addr == byte_addr(IDX_STATE);
  endfunction

  // Apply one action to a level
  function automatic logic apply_action(input logic level, input action_t act);
    case (act)
      ACT_SET: return 1'b1;
      ACT_CLEAR: return 1'b0;
      ACT_TOGGLE: return !level;
      default: return level;
    endcase
  endfunction

  // Next output level: continuous force, then one-shot force, then events
  function automatic logic next_level(input logic level, input logic [1:0] csf,
      input logic go, input action_t osf_act, input action_t ev_act);
    if (csf == CSF_LOW) begin
      return 1'b0;
    end else if (csf == CSF_HIGH) begin
      return 1'b1;
    end else if (go) begin
      return apply_action(level, osf_act);
    end
    return apply_action(level, ev_act);
  endfunction

  // Event vector; zero and period are fixed points, compares move with their values
  always_comb begin
    events = '0;
    events[EV_ZERO] = zero_match_i;
    events[EV_PRD] = period_match_i;
    events[EV_CMP_A] = compare_a_match_i;
    events[EV_CMP_B] = compare_b_match_i;
  end

  // Register write happens once both halves of the request are held
  assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

  // Write address, write data and response channels
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      // Address and data are taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        wr_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wr_data <= s_axi_wdata_i;
        wr_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      // Response follows both; unmapped addresses get an error
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Response taken, reopen both channels
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Control registers; action selections reset to no action
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctl_a <= REG_RESET;
      ctl_b <= REG_RESET;
      osf <= REG_RESET;
      csf_shadow <= REG_RESET;
      int_mask <= '0;
    end else if (wr_fire) begin
      // Action controls and one-shot force are used directly
      if (wr_addr == byte_addr(IDX_CTL_A)) begin
        ctl_a <= merge16(ctl_a, wr_data, wr_strb, CTL_MASK);
      end else if (wr_addr == byte_addr(IDX_CTL_B)) begin
        ctl_b <= merge16(ctl_b, wr_data, wr_strb, CTL_MASK);
      end else if (wr_addr == byte_addr(IDX_ONE_SHOT)) begin
        osf <= merge16(osf, wr_data, wr_strb, OSF_MASK);
      end else if (wr_addr == byte_addr(IDX_CONT_FORCE)) begin
        csf_shadow <= merge16(csf_shadow, wr_data, wr_strb, CSF_MASK);
      end else if (wr_addr == byte_addr(IDX_INT_MASK)) begin
        int_mask <= wr_data[EV_N-1:0];
      end
    end
  end

  // One-shot force strobes, one cycle after the write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      osf_go_a <= 1'b0;
      osf_go_b <= 1'b0;
    end else begin
      osf_go_a <= wr_fire && wr_addr == byte_addr(IDX_ONE_SHOT) && wr_strb[0]
        && wr_data[F_OSF_GO_A];
      osf_go_b <= wr_fire && wr_addr == byte_addr(IDX_ONE_SHOT) && wr_strb[0]
        && wr_data[F_OSF_GO_B];
    end
  end

  // Continuous force moves from shadow to active copy at counter zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      csf_active <= REG_RESET;
    end else if (zero_match_i) begin
      csf_active <= csf_shadow;
    end
  end

  // Interrupt clear bits from a status write
  always_comb begin
    int_clear = '0;
    if (wr_fire && wr_addr == byte_addr(IDX_INT_STATUS) && wr_strb[0]) begin
      int_clear = wr_data[EV_N-1:0];
    end
  end

  // Sticky event flags; a new event wins over a clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      int_status <= '0;
      irq_o <= 1'b0;
    end else begin
      int_status <= (int_status & ~int_clear) | events;
      irq_o <= |(int_status & int_mask);
    end
  end

  // Events go on to the event-trigger stage whatever their action
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      event_o <= '0;
    end else begin
      event_o <= events;
    end
  end

  // Resolver connections, one per output
  action_if a_bus();
  action_if b_bus();
  assign a_bus.zero_match = zero_match_i;
  assign a_bus.period_match = period_match_i;
  assign a_bus.cmp_a_match = compare_a_match_i;
  assign a_bus.cmp_b_match = compare_b_match_i;
  assign a_bus.dir_up = count_dir_up_i;
  assign a_bus.mode = count_mode_t'(count_mode_i);
  assign a_bus.ctl = ctl_a;
  assign b_bus.zero_match = zero_match_i;
  assign b_bus.period_match = period_match_i;
  assign b_bus.cmp_a_match = compare_a_match_i;
  assign b_bus.cmp_b_match = compare_b_match_i;
  assign b_bus.dir_up = count_dir_up_i;
  assign b_bus.mode = count_mode_t'(count_mode_i);
  assign b_bus.ctl = ctl_b;

  // Output A resolver
  action_resolver u_resolve_a (
    .bus(a_bus.resolver)
  );

  // Output B resolver
  action_resolver u_resolve_b (
    .bus(b_bus.resolver)
  );

  // PWM output registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pwm_out_a_o <= 1'b0;
      pwm_out_b_o <= 1'b0;
    end else begin
      pwm_out_a_o <= next_level(pwm_out_a_o, csf_active[F_CSF_A +: 2], osf_go_a,
        field_action(osf, F_OSF_ACT_A), a_bus.action);
      pwm_out_b_o <= next_level(pwm_out_b_o, csf_active[F_CSF_B +: 2], osf_go_b,
        field_action(osf, F_OSF_ACT_B), b_bus.action);
    end
  end

  // Read mux
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr_i == byte_addr(IDX_CTL_A)) begin
      rd_word = AXI_DW'(ctl_a);
    end else if (s_axi_araddr_i == byte_addr(IDX_CTL_B)) begin
      rd_word = AXI_DW'(ctl_b);
    end else if (s_axi_araddr_i == byte_addr(IDX_ONE_SHOT)) begin
      rd_word = AXI_DW'(osf);
    end else if (s_axi_araddr_i == byte_addr(IDX_CONT_FORCE)) begin
      rd_word = AXI_DW'(csf_shadow);
    end else if (s_axi_araddr_i == byte_addr(IDX_INT_STATUS)) begin
      rd_word = AXI_DW'(int_status);
    end else if (s_axi_araddr_i == byte_addr(IDX_INT_MASK)) begin
      rd_word = AXI_DW'(int_mask);
    end else if (s_axi_araddr_i == byte_addr(IDX_STATE)) begin
      rd_word[ST_PWM_A] = pwm_out_a_o;
      rd_word[ST_PWM_B] = pwm_out_b_o;
      rd_word[ST_DIR] = count_dir_up_i;
    end
  end

  // Read address and read data channels
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic force_a; // Any force acting on output A
  assign force_a = csf_active[F_CSF_A +: 2] == CSF_LOW
    || csf_active[F_CSF_A +: 2] == CSF_HIGH || osf_go_a;

  chk_set_drives_high: assert property (
    (!force_a && a_bus.action == ACT_SET) |=> pwm_out_a_o)
    else $error("set action did not drive output A high");

  chk_clear_drives_low: assert property (
    (!force_a && a_bus.action == ACT_CLEAR) |=> !pwm_out_a_o)
    else $error("clear action did not drive output A low");

  chk_toggle_inverts: assert property (
    (!force_a && a_bus.action == ACT_TOGGLE) |=> pwm_out_a_o != $past(pwm_out_a_o))
    else $error("toggle action did not invert output A");

  chk_none_holds: assert property (
    (!force_a && a_bus.action == ACT_NONE) |=> $stable(pwm_out_a_o))
    else $error("output A moved without an action");

  chk_event_forwarded: assert property (
    (zero_match_i && compare_b_match_i) |=> event_o[EV_ZERO] && event_o[EV_CMP_B]
      && int_status[EV_ZERO])
    else $error("event not forwarded or not flagged");

  chk_reset_no_action: assert property (
    $rose(rst_n_i) |-> ctl_a == REG_RESET && ctl_b == REG_RESET)
    else $error("action selections not cleared by reset");

  chk_shadow_load: assert property (
    !zero_match_i |=> $stable(csf_active))
    else $error("continuous force changed away from counter zero");

  chk_force_wins: assert property (
    (osf_go_a && !csf_active[F_CSF_A] && !csf_active[F_CSF_A + 1]
      && field_action(osf, F_OSF_ACT_A) == ACT_CLEAR) |=> !pwm_out_a_o)
    else $error("one-shot clear lost against an event");

  chk_up_period_first: assert property (
    (a_bus.mode == MODE_UP && period_match_i
      && field_action(ctl_a, F_PRD) != ACT_NONE) |-> a_bus.action == field_action(ctl_a, F_PRD))
    else $error("period match lost priority in up mode");

  chk_down_zero_first: assert property (
    (a_bus.mode == MODE_DOWN && zero_match_i
      && field_action(ctl_a, F_ZERO) != ACT_NONE) |-> a_bus.action == field_action(ctl_a, F_ZERO))
    else $error("zero match lost priority in down mode");
endmodule

// >>> tb/gate_driver_model.sv
module gate_driver_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Gate drive levels
  input wire logic hi_a_i,
  input wire logic hi_b_i,
  // Switch-on counts
  output int on_a_o,
  output int on_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_a; // Previous gate A level
  logic last_b; // Previous gate B level
  // Counts each switch-on, so a spurious pulse between checks still shows
  always_ff @(posedge clk_i) begin
    last_a <= hi_a_i;
    last_b <= hi_b_i;
    if (!rst_n_i) begin
      on_a_o <= 0;
      on_b_o <= 0;
    end else begin
      on_a_o <= on_a_o + int'(hi_a_i && !last_a);
      on_b_o <= on_b_o + int'(hi_b_i && !last_b);
    end
  end
endmodule

// >>> tb/pwm_action_qualifier_tb.sv
module pwm_action_qualifier_tb import aq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // Time-base clock
  logic rst_n = 1'b0; // Reset, active low
  logic [7:0] awaddr = 8'h00; // Bus master signals
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, a_o, b_o, irq; // Design outputs
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ev = 4'h0; // Event pulses in
  logic [3:0] ev_o; // Forwarded events
  logic [1:0] mode = 2'h0; // Counter mode
  logic dir = 1'b1; // Counting up
  int on_a, on_b; // Gate switch-on counts
  int fails = 0;
  int total_checks = 0;

  pwm_action_qualifier pwm_action_qualifier_i (.ref_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .zero_match_i(ev[0]),
    .period_match_i(ev[1]), .compare_a_match_i(ev[2]), .compare_b_match_i(ev[3]),
    .count_dir_up_i(dir), .count_mode_i(mode), .pwm_out_a_o(a_o), .pwm_out_b_o(b_o),
    .event_o(ev_o), .irq_o(irq));

  gate_driver_model gate_driver_model_i (.clk_i(clk), .rst_n_i(rst_n), .hi_a_i(a_o),
    .hi_b_i(b_o), .on_a_o(on_a), .on_b_o(on_b));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // Byte address of a word index
  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  // One bus write; address and data offered together, response awaited
  task automatic wchk(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= ba(idx);
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      fails++;
      close_out();
    end
    chk(32'(bresp), 32'(er), "write response");
  endtask

  // One bus read, data and response compared
  task automatic rchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      fails++;
      close_out();
    end
    chk(rdata, ed, "read data");
    chk(32'(rresp), 32'(er), "read response");
  endtask

  // Output levels after the current edge has settled
  task automatic lv(input logic xa, input logic xb);
    #1 chk(32'({a_o, b_o}), 32'({xa, xb}), "pwm levels");
  endtask

  // One-cycle event pulse, forwarded copy and resulting levels checked
  task automatic pulse(input logic [3:0] e, input logic xa, input logic xb);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
    #1 chk(32'(ev_o), 32'(e), "forwarded events");
    @(posedge clk);
    lv(xa, xb);
  endtask

  // Mode change at a clock edge
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(IDX_CTL_A, 32'h0, RESP_OKAY);
    rchk(IDX_CTL_B, 32'h0, RESP_OKAY);
    rchk(IDX_CONT_FORCE, 32'h0, RESP_OKAY);
    rchk(8'h0f, 32'h0, RESP_SLVERR);
    wchk(8'h0f, 16'h0006, RESP_SLVERR);
    pulse(4'hf, 1'b0, 1'b0);
    $display("Test reset defaults done");
    wchk(IDX_CTL_A, 16'h0006, RESP_OKAY);
    wchk(IDX_CTL_B, 16'h0030, RESP_OKAY);
    rchk(IDX_CTL_A, 32'h6, RESP_OKAY);
    pulse(4'h1, 1'b1, 1'b0);
    pulse(4'h2, 1'b0, 1'b0);
    pulse(4'h4, 1'b0, 1'b1);
    pulse(4'h4, 1'b0, 1'b0);
    set_mode(2'h1);
    pulse(4'h4, 1'b0, 1'b0);
    $display("Test actions done");
    set_mode(2'h0);
    pulse(4'h3, 1'b0, 1'b0);
    set_mode(2'h1);
    pulse(4'h3, 1'b1, 1'b0);
    wchk(IDX_CTL_B, 16'h0210, RESP_OKAY);
    set_mode(2'h0);
    pulse(4'hc, 1'b1, 1'b1);
    wchk(IDX_CTL_B, 16'h0480, RESP_OKAY);
    set_mode(2'h1);
    pulse(4'hc, 1'b1, 1'b0);
    wchk(IDX_STATE, 16'h0000, RESP_OKAY);
    rchk(IDX_STATE, 32'h5, RESP_OKAY);
    $display("Test priority done");
    set_mode(2'h0);
    wchk(IDX_ONE_SHOT, 16'h0005, RESP_OKAY);
    repeat (3) @(posedge clk);
    lv(1'b0, 1'b0);
    rchk(IDX_ONE_SHOT, 32'h1, RESP_OKAY);
    wchk(IDX_ONE_SHOT, 16'h0006, RESP_OKAY);
    repeat (3) @(posedge clk);
    lv(1'b1, 1'b0);
    wchk(IDX_ONE_SHOT, 16'h0038, RESP_OKAY);
    repeat (3) @(posedge clk);
    lv(1'b1, 1'b1);
    $display("Test one-shot force done");
    wchk(IDX_CONT_FORCE, 16'h0001, RESP_OKAY);
    repeat (4) @(posedge clk);
    lv(1'b1, 1'b1);
    rchk(IDX_CONT_FORCE, 32'h1, RESP_OKAY);
    pulse(4'h1, 1'b0, 1'b1);
    pulse(4'h1, 1'b0, 1'b1);
    wchk(IDX_CONT_FORCE, 16'h0000, RESP_OKAY);
    pulse(4'h1, 1'b0, 1'b1);
    pulse(4'h1, 1'b1, 1'b1);
    $display("Test continuous force done");
    rchk(IDX_INT_STATUS, 32'hf, RESP_OKAY);
    wchk(IDX_INT_MASK, 16'h0000, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "interrupt while masked");
    wchk(IDX_INT_MASK, 16'h000f, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "interrupt when unmasked");
    wchk(IDX_INT_STATUS, 16'h000f, RESP_OKAY);
    rchk(IDX_INT_STATUS, 32'h0, RESP_OKAY);
    chk(32'(irq), 32'h0, "interrupt after clear");
    pulse(4'h4, 1'b1, 1'b1);
    rchk(IDX_INT_STATUS, 32'h4, RESP_OKAY);
    chk(32'(on_a), 32'd4, "gate A switch-ons");
    chk(32'(on_b), 32'd3, "gate B switch-ons");
    $display("Test interrupts done");
    set_mode(2'h2);
    wchk(IDX_CTL_A, 16'h0096, RESP_OKAY);
    pulse(4'h5, 1'b0, 1'b1);
    @(posedge clk);
    dir <= 1'b0;
    pulse(4'h4, 1'b1, 1'b1);
    pulse(4'h9, 1'b1, 1'b0);
    set_mode(2'h3);
    wchk(IDX_CONT_FORCE, 16'h0008, RESP_OKAY);
    pulse(4'hf, 1'b1, 1'b1);
    rchk(IDX_STATE, 32'h3, RESP_OKAY);
    $display("Test up-down and frozen done");
    close_out();
  end
endmodule
